// File: inc/alu_flags_pkg.sv
// Shared constants, operation codes and flag layout of the ALU flag block.
`default_nettype none
package alu_flags_pkg;

    localparam int DATA_W = 8;
    localparam int FLAG_W = 5;
    localparam int OP_W = 4;

    // Bit positions of the flags inside the status register.
    localparam int CARRY_BIT = 0;
    localparam int NIBBLE_BIT = 1;
    localparam int ZERO_BIT = 2;
    localparam int OVF_BIT = 3;
    localparam int NEG_BIT = 4;
    localparam int SIGN_BIT = 7;
    localparam int NIBBLE_MSB = 3;

    // Flag masks, one bit per flag.
    localparam logic [4:0] MASK_NONE = 5'h00;
    localparam logic [4:0] MASK_ALL = 5'h1f;
    localparam logic [4:0] MASK_ZN = 5'h14;
    localparam logic [4:0] MASK_Z = 5'h04;
    localparam logic [4:0] FLAGS_RESET = 5'h00;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [4:0] STATUS_OFS = 5'h00;
    localparam logic [4:0] FILE_OFS = 5'h04;
    localparam logic [4:0] WREG_OFS = 5'h08;
    localparam logic [4:0] CMD_OFS = 5'h0c;
    localparam logic [4:0] RESULT_OFS = 5'h10;
    localparam int ADDR_W = 5;

    // Command register fields.
    localparam int CMD_DEST_BIT = 7;
    localparam int CMD_PEND_BIT = 8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [3:0] {
        OP_ADD_W_TO_FILE,
        OP_ADD_LITERAL_TO_W,
        OP_SUBTRACT_W_FROM_LITERAL,
        OP_SUBTRACT_W_FROM_FILE,
        OP_AND,
        OP_IOR,
        OP_XOR,
        OP_CLEAR,
        OP_MOVE,
        OP_SWAP
    } op_e;

    // Flags that an operation writes; others keep their value, but an op with no flags that targets the status loads all five from the result.
    function automatic logic [4:0] op_flag_mask(input logic [3:0] op);
        case (op)
            OP_ADD_W_TO_FILE, OP_ADD_LITERAL_TO_W,
            OP_SUBTRACT_W_FROM_LITERAL, OP_SUBTRACT_W_FROM_FILE: begin
                op_flag_mask = MASK_ALL;
            end
            OP_AND, OP_IOR, OP_XOR: op_flag_mask = MASK_ZN;
            OP_CLEAR: op_flag_mask = MASK_Z;
            default: op_flag_mask = MASK_NONE;
        endcase
    endfunction

    // True for the two subtracting operations.
    function automatic logic op_is_sub(input logic [3:0] op);
        op_is_sub = (op == OP_SUBTRACT_W_FROM_LITERAL) ||
                    (op == OP_SUBTRACT_W_FROM_FILE);
    endfunction

endpackage
`default_nettype wire

// File: rtl/alu_condition_flags.sv
// Condition-flag register of an 8-bit ALU with an AXI4-Lite slave port.
`default_nettype none
module alu_condition_flags (
    input wire logic clk_in,
    input wire logic rst_in,
    // Execution port from the core.
    input wire logic exec_valid_in,
    input wire logic [3:0] exec_op_in,
    input wire logic [7:0] exec_file_in,
    input wire logic [7:0] exec_w_in,
    input wire logic exec_dest_status_in,
    output logic [7:0] result_out,
    output logic result_valid_out,
    output logic [4:0] flags_out,
    // AXI4-Lite slave.
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Flag and data state.
    logic [4:0] flags_ff;
    logic [4:0] nxt_flags;
    logic [7:0] result_ff;
    logic result_valid_ff;
    logic [7:0] file_reg_ff;
    logic [7:0] w_reg_ff;
    logic [3:0] cmd_op_ff;
    logic cmd_dest_ff;
    logic cmd_pend_ff;

    // Bus channel state.
    logic aw_full_ff;
    logic w_full_ff;
    logic [4:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    // Shared execution path.
    logic exec_go;
    logic sw_take;
    logic [3:0] sel_op;
    logic [7:0] sel_file;
    logic [7:0] sel_w;
    logic sel_dest;
    logic [7:0] alu_result;
    logic [4:0] alu_flags;

    // Write decode.
    logic wr_go;
    logic lane0;
    logic wr_status;
    logic wr_file;
    logic wr_wreg;
    logic wr_cmd;
    logic wr_hit;

    // True when the byte offset names a register of this block.
    function automatic logic ofs_mapped(input logic [4:0] ofs);
        ofs_mapped = (ofs == alu_flags_pkg::STATUS_OFS) ||
                     (ofs == alu_flags_pkg::FILE_OFS) ||
                     (ofs == alu_flags_pkg::WREG_OFS) ||
                     (ofs == alu_flags_pkg::CMD_OFS) ||
                     (ofs == alu_flags_pkg::RESULT_OFS);
    endfunction

    // Core execution wins the ALU; a software command waits for a free
    // cycle, so software issue is best effort under a busy core.
    assign sw_take = cmd_pend_ff && !exec_valid_in;
    assign exec_go = exec_valid_in || sw_take;
    assign sel_op = exec_valid_in ? exec_op_in : cmd_op_ff;
    assign sel_file = exec_valid_in ? exec_file_in : file_reg_ff;
    assign sel_w = exec_valid_in ? exec_w_in : w_reg_ff;
    assign sel_dest = exec_valid_in ? exec_dest_status_in : cmd_dest_ff;

    alu_flag_unit u_alu (
        .op_in(sel_op),
        .file_in(sel_file),
        .w_in(sel_w),
        .result_out(alu_result),
        .flags_out(alu_flags)
    );

    // Write decode happens once both address and data are held.
    assign wr_go = aw_full_ff && w_full_ff && !bvalid_ff;
    assign lane0 = w_strb_ff[0];
    assign wr_hit = ofs_mapped(aw_addr_ff);
    assign wr_status = wr_go && lane0 &&
                       (aw_addr_ff == alu_flags_pkg::STATUS_OFS);
    assign wr_file = wr_go && lane0 &&
                     (aw_addr_ff == alu_flags_pkg::FILE_OFS);
    assign wr_wreg = wr_go && lane0 &&
                     (aw_addr_ff == alu_flags_pkg::WREG_OFS);
    assign wr_cmd = wr_go && lane0 &&
                    (aw_addr_ff == alu_flags_pkg::CMD_OFS);

    status_write_merge u_merge (
        .cur_flags_in(flags_ff),
        .sw_we_in(wr_status),
        .sw_flags_in(w_data_ff[4:0]),
        .exec_in(exec_go),
        .op_in(sel_op),
        .dest_status_in(sel_dest),
        .result_in(alu_result),
        .alu_flags_in(alu_flags),
        .nxt_flags_out(nxt_flags)
    );

    // Flag register; unknown at power-on in the part, cleared here so
    // that simulation starts from a defined value.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            flags_ff <= alu_flags_pkg::FLAGS_RESET;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // Last result and its one-cycle valid strobe.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            result_ff <= 8'h00;
            result_valid_ff <= 1'b0;
        end else begin
            result_valid_ff <= exec_go;
            if (exec_go) begin
                result_ff <= alu_result;
            end
        end
    end

    // Software operand registers.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            file_reg_ff <= 8'h00;
            w_reg_ff <= 8'h00;
        end else begin
            if (wr_file) begin
                file_reg_ff <= w_data_ff[7:0];
            end
            if (wr_wreg) begin
                w_reg_ff <= w_data_ff[7:0];
            end
        end
    end

    // Command register; a new write sets pending and wins over the
    // clear of a command taken in the same cycle.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_op_ff <= 4'h0;
            cmd_dest_ff <= 1'b0;
            cmd_pend_ff <= 1'b0;
        end else begin
            if (wr_cmd) begin
                cmd_op_ff <= w_data_ff[3:0];
                cmd_dest_ff <= w_data_ff[alu_flags_pkg::CMD_DEST_BIT];
                cmd_pend_ff <= 1'b1;
            end else if (sw_take) begin
                cmd_pend_ff <= 1'b0;
            end
        end
    end

    // Write address channel: one write in flight at a time.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            aw_full_ff <= 1'b0;
            aw_addr_ff <= 5'h00;
            awready_ff <= 1'b1;
        end else begin
            if (s_axi_awvalid && awready_ff) begin
                aw_full_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
                awready_ff <= 1'b0;
            end else if (wr_go) begin
                aw_full_ff <= 1'b0;
            end else if (bvalid_ff && s_axi_bready) begin
                awready_ff <= 1'b1;
            end
        end
    end

    // Write data channel, independent of the address order.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            w_full_ff <= 1'b0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            wready_ff <= 1'b1;
        end else begin
            if (s_axi_wvalid && wready_ff) begin
                w_full_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
                wready_ff <= 1'b0;
            end else if (wr_go) begin
                w_full_ff <= 1'b0;
            end else if (bvalid_ff && s_axi_bready) begin
                wready_ff <= 1'b1;
            end
        end
    end

    // Write response; unmapped offsets answer with a decode error.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= alu_flags_pkg::RESP_OKAY;
        end else begin
            if (wr_go) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? alu_flags_pkg::RESP_OKAY :
                                     alu_flags_pkg::RESP_DECERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Read channel: data is sampled at the address handshake and shown
    // in the next cycle; unused upper bits read as zero.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= alu_flags_pkg::RESP_OKAY;
        end else begin
            if (s_axi_arvalid && arready_ff) begin
                arready_ff <= 1'b0;
                rvalid_ff <= 1'b1;
                rresp_ff <= ofs_mapped(s_axi_araddr) ?
                            alu_flags_pkg::RESP_OKAY :
                            alu_flags_pkg::RESP_DECERR;
                case (s_axi_araddr)
                    alu_flags_pkg::STATUS_OFS: begin
                        rdata_ff <= {27'h0000000, flags_ff};
                    end
                    alu_flags_pkg::FILE_OFS: begin
                        rdata_ff <= {24'h000000, file_reg_ff};
                    end
                    alu_flags_pkg::WREG_OFS: begin
                        rdata_ff <= {24'h000000, w_reg_ff};
                    end
                    alu_flags_pkg::CMD_OFS: begin
                        rdata_ff <= {23'h000000, cmd_pend_ff, cmd_dest_ff,
                                     3'h0, cmd_op_ff};
                    end
                    alu_flags_pkg::RESULT_OFS: begin
                        rdata_ff <= {24'h000000, result_ff};
                    end
                    default: rdata_ff <= 32'h0000_0000;
                endcase
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

    // Every output is a flip-flop.
    assign result_out = result_ff;
    assign result_valid_out = result_valid_ff;
    assign flags_out = flags_ff;
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rvalid = rvalid_ff;
endmodule
`default_nettype wire

// File: rtl/alu_flag_unit.sv
// Combinational ALU that produces a result and its five condition flags.
`default_nettype none
module alu_flag_unit (
    input wire logic [3:0] op_in,
    input wire logic [7:0] file_in,
    input wire logic [7:0] w_in,
    output logic [7:0] result_out,
    output logic [4:0] flags_out
);
    logic sub;
    logic [7:0] addend;
    logic [8:0] sum;
    logic [4:0] low_sum;

    // Subtraction adds the inverted operand plus one.
    assign sub = alu_flags_pkg::op_is_sub(op_in);
    assign addend = sub ? ~w_in : w_in;
    assign sum = {1'b0, file_in} + {1'b0, addend} + {8'h00, sub};
    assign low_sum = {1'b0, file_in[3:0]} + {1'b0, addend[3:0]} +
                     {4'h0, sub};

    // Result selection per operation.
    always_comb begin
        case (op_in)
            alu_flags_pkg::OP_AND: result_out = file_in & w_in;
            alu_flags_pkg::OP_IOR: result_out = file_in | w_in;
            alu_flags_pkg::OP_XOR: result_out = file_in ^ w_in;
            alu_flags_pkg::OP_CLEAR: result_out = 8'h00;
            alu_flags_pkg::OP_MOVE: result_out = file_in;
            alu_flags_pkg::OP_SWAP: result_out = {file_in[3:0], file_in[7:4]};
            default: result_out = sum[7:0];
        endcase
    end

    // Flags; carries double as inverted borrows when subtracting.
    always_comb begin
        flags_out[alu_flags_pkg::CARRY_BIT] = sum[8];
        flags_out[alu_flags_pkg::NIBBLE_BIT] =
            low_sum[alu_flags_pkg::NIBBLE_MSB + 1];
        flags_out[alu_flags_pkg::ZERO_BIT] = (result_out == 8'h00);
        flags_out[alu_flags_pkg::OVF_BIT] =
            (file_in[alu_flags_pkg::SIGN_BIT] ==
             addend[alu_flags_pkg::SIGN_BIT]) &&
            (sum[alu_flags_pkg::SIGN_BIT] !=
             file_in[alu_flags_pkg::SIGN_BIT]);
        flags_out[alu_flags_pkg::NEG_BIT] =
            result_out[alu_flags_pkg::SIGN_BIT];
    end
endmodule
`default_nettype wire

// File: rtl/status_write_merge.sv
// Next value of the flags from software writes and executed operations.
`default_nettype none
module status_write_merge (
    input wire logic [4:0] cur_flags_in,
    input wire logic sw_we_in,
    input wire logic [4:0] sw_flags_in,
    input wire logic exec_in,
    input wire logic [3:0] op_in,
    input wire logic dest_status_in,
    input wire logic [7:0] result_in,
    input wire logic [4:0] alu_flags_in,
    output logic [4:0] nxt_flags_out
);
    logic [4:0] base;
    logic [4:0] mask;

    // A software write lands first so that a flag event in the same
    // cycle overrides it and is never lost.
    always_comb begin
        base = sw_we_in ? sw_flags_in : cur_flags_in;
        mask = alu_flags_pkg::op_flag_mask(op_in);
        nxt_flags_out = base;
        if (exec_in) begin
            if (dest_status_in && (mask == alu_flags_pkg::MASK_NONE)) begin
                nxt_flags_out = result_in[4:0];
            end else begin
                // Result write to the flags is dropped here.
                nxt_flags_out = (alu_flags_in & mask) | (base & ~mask);
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/alu_condition_flags_monitor.sv
// Assertion checker for the ALU condition-flag block.
`default_nettype none
module alu_condition_flags_monitor (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic exec_valid_in,
    input wire logic [3:0] exec_op_in,
    input wire logic [7:0] exec_file_in,
    input wire logic [7:0] exec_w_in,
    input wire logic exec_dest_status_in,
    input wire logic [7:0] result_out,
    input wire logic result_valid_out,
    input wire logic [4:0] flags_out,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp
);
    logic is_sub;
    logic is_arith;
    logic is_logic;
    logic [7:0] opb;
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic [4:0] exp_q;
    logic [7:0] res_q;
    // Reference adder: a subtraction adds the inverted operand plus one.
    always_comb begin
        is_sub = (exec_op_in == 4'h2) || (exec_op_in == 4'h3);
        is_arith = exec_valid_in && (exec_op_in <= 4'h3);
        is_logic = exec_valid_in && !exec_dest_status_in;
        is_logic = is_logic && (exec_op_in <= 4'h6);
        opb = is_sub ? ~exec_w_in : exec_w_in;
        sum9 = {1'b0, exec_file_in} + {1'b0, opb} + {8'h00, is_sub};
        nib5 = {1'b0, exec_file_in[3:0]} + {1'b0, opb[3:0]} + {4'h0, is_sub};
    end
    // Expected flags are held one cycle so they line up with the outputs.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            exp_q <= 5'h00;
            res_q <= 8'h00;
        end else begin
            exp_q <= {sum9[7], (exec_file_in[7] == opb[7]) &&
                      (sum9[7] != exec_file_in[7]), sum9[7:0] == 8'h00,
                      nib5[4], sum9[8]};
            res_q <= sum9[7:0];
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_carry_msb: assert property (
        is_arith |=> flags_out[0] == exp_q[0])
        else $error("carry flag wrong after add or subtract");
    a_nibble_carry: assert property (
        is_arith |=> flags_out[1] == exp_q[1])
        else $error("nibble carry flag wrong");
    a_signed_overflow: assert property (
        is_arith |=> flags_out[3] == exp_q[3])
        else $error("overflow flag wrong");
    a_neg_mirror: assert property (
        is_logic |=> flags_out[4] == result_out[7])
        else $error("negative flag does not follow result msb");
    a_zero_result: assert property (
        is_logic |=> flags_out[2] == (result_out == 8'h00))
        else $error("zero flag does not match result");
    a_twos_sum: assert property (
        is_arith && !exec_dest_status_in |=> result_out == res_q)
        else $error("add or subtract result wrong");
    a_dest_keeps_alu: assert property (
        is_arith && exec_dest_status_in |=> flags_out == exp_q)
        else $error("flags not from alu when status is target");
    a_result_pulse: assert property (
        exec_valid_in |=> result_valid_out)
        else $error("result valid missing after op");
    a_bresp_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    c_add_carry: cover property (is_arith && !is_sub && sum9[8]);
    c_sub_borrow: cover property (is_arith && is_sub && !sum9[8]);
    c_dest_status: cover property (is_arith && exec_dest_status_in);
endmodule
bind alu_condition_flags alu_condition_flags_monitor mon (.clk_in, .rst_in,
    .exec_valid_in, .exec_op_in, .exec_file_in, .exec_w_in,
    .exec_dest_status_in, .result_out, .result_valid_out, .flags_out,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp);
`default_nettype wire

// File: tb/alu_condition_flags_tb.sv
// Self-checking testbench of the ALU condition-flag block.
`default_nettype none
module alu_condition_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic rst_in, ev, ed, rv, awv, awr, wv, wr, bv, br, arv, arr, rvl, rr;
    logic [3:0] eop, wstrb;
    logic [7:0] ef, ew, res;
    logic [4:0] flags, awa, ara;
    logic [31:0] wd, rd;
    logic [1:0] bresp, rresp;
    int err_total = 0;
    int n_checks = 0;

    alu_condition_flags dut (.clk_in(clk_in), .rst_in(rst_in),
        .exec_valid_in(ev), .exec_op_in(eop), .exec_file_in(ef),
        .exec_w_in(ew), .exec_dest_status_in(ed), .result_out(res),
        .result_valid_out(rv), .flags_out(flags), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rvl),
        .s_axi_rready(rr));

    // Free-running 50 MHz clock.
    always #10 clk_in = ~clk_in;

    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Bench's own adder model: {result, N, OV, Z, DC, C}.
    function automatic logic [12:0] ref_op(input logic [3:0] op,
                                           input logic [7:0] f, w);
        logic s;
        logic [7:0] b;
        logic [8:0] r;
        logic [4:0] n;
        s = (op == 4'h2) || (op == 4'h3);
        b = s ? ~w : w;
        r = {1'b0, f} + {1'b0, b} + {8'h00, s};
        n = {1'b0, f[3:0]} + {1'b0, b[3:0]} + {4'h0, s};
        return {r[7:0], r[7], (f[7] == b[7]) && (r[7] != f[7]),
                r[7:0] == 8'h00, n[4], r[8]};
    endfunction

    // One executed op; returns once its outputs have settled.
    task automatic run_op(input logic [3:0] op, input logic [7:0] f, w,
                          input logic dst);
        @(posedge clk_in);
        ev <= 1'b1;
        eop <= op;
        ef <= f;
        ew <= w;
        ed <= dst;
        @(posedge clk_in);
        ev <= 1'b0;
        #1;
    endtask

    // Address and data are offered together and dropped once each is taken.
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk_in);
        awa <= a;
        awv <= 1'b1;
        wd <= d;
        wv <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_in);
            if (awv && awr) aw_ok = 1'b1;
            if (wv && wr) w_ok = 1'b1;
            if (aw_ok) awv <= 1'b0;
            if (w_ok) wv <= 1'b0;
        end
        br <= 1'b1;
        do @(posedge clk_in); while (!bv);
        r = bresp;
        br <= 1'b0;
    endtask

    task automatic axi_rd(input logic [4:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge clk_in);
        ara <= a;
        arv <= 1'b1;
        do @(posedge clk_in); while (!arr);
        arv <= 1'b0;
        rr <= 1'b1;
        do @(posedge clk_in); while (!rvl);
        d = rd;
        r = rresp;
        rr <= 1'b0;
    endtask

    task automatic t_arith;
        logic [7:0] fa [6] = '{8'h7f, 8'hff, 8'h05, 8'h00, 8'h80, 8'h08};
        logic [7:0] wa [6] = '{8'h01, 8'h01, 8'h05, 8'h01, 8'h01, 8'h08};
        logic [12:0] e;
        for (int op = 0; op < 4; op++) begin
            for (int i = 0; i < 6; i++) begin
                run_op(op[3:0], fa[i], wa[i], 1'b0);
                e = ref_op(op[3:0], fa[i], wa[i]);
                chk("result", res, e[12:5]);
                chk("flags", flags, e[4:0]);
                chk("result_valid", rv, 1);
            end
        end
        $display("arith table done");
    endtask

    // Logic ops touch Z and N only; clear touches Z; move and swap none.
    task automatic t_logic;
        run_op(4'h0, 8'hff, 8'h01, 1'b0);
        chk("flags", flags, 5'h07);
        run_op(4'h4, 8'hf0, 8'h80, 1'b0);
        chk("flags", flags, 5'h13);
        run_op(4'h5, 8'h00, 8'h00, 1'b0);
        chk("flags", flags, 5'h07);
        run_op(4'h6, 8'h0f, 8'hf0, 1'b0);
        chk("result", res, 8'hff);
        chk("flags", flags, 5'h13);
        run_op(4'h7, 8'h55, 8'h55, 1'b0);
        chk("flags", flags, 5'h17);
        run_op(4'h8, 8'h00, 8'h00, 1'b0);
        run_op(4'h9, 8'h00, 8'h00, 1'b0);
        chk("flags", flags, 5'h17);
        $display("logic ops done");
    endtask

    // Two ops on consecutive edges, then ops that target the status.
    task automatic t_b2b_dest;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk_in);
        ev <= 1'b1;
        {eop, ef, ew, ed} <= {4'h0, 8'h7f, 8'h01, 1'b0};
        @(posedge clk_in);
        {eop, ef, ew} <= {4'h3, 8'h00, 8'h01};
        #1;
        chk("flags", flags, 5'h1a);
        @(posedge clk_in);
        ev <= 1'b0;
        #1;
        chk("flags", flags, 5'h10);
        run_op(4'h0, 8'h01, 8'h01, 1'b0);
        run_op(4'h7, 8'h00, 8'h00, 1'b1);
        chk("flags", flags, 5'h04);
        run_op(4'h0, 8'h7f, 8'h01, 1'b1);
        chk("flags", flags, 5'h1a);
        axi_rd(5'h00, d, r);
        chk("status", d, 32'h0000001a);
        $display("back to back and status target done");
    endtask

    task automatic t_axi;
        logic [31:0] d;
        logic [1:0] r;
        logic [12:0] e;
        axi_wr(5'h00, 32'h000000ff, r);
        chk("bresp", r, 2'h0);
        axi_rd(5'h00, d, r);
        chk("status", d, 32'h0000001f);
        axi_wr(5'h14, 32'h00000001, r);
        chk("bresp", r, 2'h3);
        axi_rd(5'h14, d, r);
        chk("rresp", r, 2'h3);
        chk("rdata", d, 32'h0);
        axi_wr(5'h04, 32'h00000080, r);
        axi_wr(5'h08, 32'h00000001, r);
        axi_wr(5'h0c, 32'h00000003, r);
        e = ref_op(4'h3, 8'h80, 8'h01);
        axi_rd(5'h10, d, r);
        chk("result", d, {24'h0, e[12:5]});
        axi_rd(5'h00, d, r);
        chk("status", d, {27'h0, e[4:0]});
        $display("register access done");
    endtask

    // Move to status, spare codes, lane strobe, write racing an op, reset.
    task automatic t_corner;
        logic [31:0] d;
        logic [1:0] r;
        run_op(4'h8, 8'h15, 8'h00, 1'b1);
        chk("flags", flags, 5'h15);
        run_op(4'ha, 8'h7f, 8'h01, 1'b0);
        chk("result", res, 8'h80);
        chk("flags", flags, 5'h15);
        axi_rd(5'h0c, d, r);
        chk("command", d, 32'h00000003);
        wstrb <= 4'he;
        axi_wr(5'h04, 32'h00000011, r);
        wstrb <= 4'hf;
        chk("bresp", r, 2'h0);
        axi_rd(5'h04, d, r);
        chk("file", d, 32'h00000080);
        // The op lands in the commit cycle of the status write and wins.
        fork
            axi_wr(5'h00, 32'h00000000, r);
            begin
                @(posedge clk_in);
                run_op(4'h4, 8'hf0, 8'h80, 1'b0);
            end
        join
        chk("flags", flags, 5'h10);
        @(posedge clk_in);
        rst_in <= 1'b1;
        @(posedge clk_in);
        rst_in <= 1'b0;
        #1;
        chk("flags", flags, 5'h00);
        chk("result", res, 8'h00);
        $display("corner cases done");
    endtask

    // Cuts a hang short well past the expected run length.
    initial begin
        repeat (20000) @(posedge clk_in);
        err_total++;
        finish_test();
    end

    initial begin
        {rst_in, ev, ed, awv, wv, br, arv, rr} = 8'h80;
        {eop, ef, ew, awa, ara, wd} = '0;
        wstrb = 4'hf;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        #1;
        chk("flags", flags, 5'h00);
        chk("result_valid", rv, 1'b0);
        t_arith();
        t_logic();
        t_b2b_dest();
        t_axi();
        t_corner();
        finish_test();
    end
endmodule
`default_nettype wire
